// >>> logic/ccd_top.sv
// clock configuration register decode, source switch and prescaler ticks
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none

// divider in source events; new ratio and source taken only at wrap
module ccd_tick #(
    parameter int W = 10
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         src_a,
    input  wire logic         src_b,
    input  wire logic         sel_b,
    input  wire logic [W-1:0] ratio,
    output logic              tick_q
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] ratio_q;
    logic         sel_q;
    logic         ev;

    // the counter needs two bits at least to tell a wrap from a count
    if (W < 2) begin : g_width_check
        $error("ccd_tick width too small");
    end

    assign ev = sel_q ? src_b : src_a;

    // reload only at wrap so no period is cut short
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= '0;
            ratio_q <= W'(1);
            sel_q   <= 1'b0;
            tick_q  <= 1'b0;
        end else begin
            tick_q <= ev && (cnt_q == ratio_q - W'(1));
            if (ev) begin
                if (cnt_q == ratio_q - W'(1)) begin
                    cnt_q   <= '0;
                    ratio_q <= ratio;
                    sel_q   <= sel_b;
                end else begin
                    cnt_q <= cnt_q + W'(1);
                end
            end
        end
    end

    chk_tick_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        tick_q |-> cnt_q == '0)
        else $error("tick without counter wrap");
endmodule

module ccd_top (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata_q,
    input  wire logic        usb_clock_enabled,
    input  wire logic        wake_from_lowpower,
    input  wire logic        crystal_failure,
    output logic [1:0]       sysclk_in_use_q,
    output logic             pll_source_sel_q,
    output logic             pll_preselect_q,
    output logic             pll_predivide_sel_q,
    output logic [6:0]       pll_multiply_q,
    output logic [2:0]       usb_div_half_q,
    output logic             ahb_tick_q,
    output logic             apb1_tick_q,
    output logic             apb2_tick_q,
    output logic             adc_tick_q
);
    logic [1:0]  rst_sync_q;
    logic        rst_n;
    logic [5:0]  mf_q;
    logic [2:0]  usb_q;
    logic        pllsrc_q;
    logic        div0_q;
    logic        presel_q;
    logic [2:0]  adc_q;
    logic [2:0]  apb2_q;
    logic [2:0]  apb1_q;
    logic [3:0]  ahb_q;
    logic [1:0]  sel_q;
    logic [1:0]  status_q;
    logic [3:0]  sw_cnt_q;
    ccd_pkg::ccd_sw_state_t sw_q;
    logic        wr0;
    logic        wr1;
    logic        wr2;
    logic        xtal_in_use;
    logic        force_rc;
    logic [9:0]  ahb_ratio;
    logic [9:0]  apb1_ratio;
    logic [9:0]  apb2_ratio;
    logic [9:0]  adc_ratio;
    logic [31:0] cfg0_view;
    logic [31:0] cfg1_view;
    logic [31:0] cfg2_view;

    // reset released through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign wr0 = wr && (addr == ccd_pkg::CFG0_OFFSET);
    assign wr1 = wr && (addr == ccd_pkg::CFG1_OFFSET);
    assign wr2 = wr && (addr == ccd_pkg::CFG2_OFFSET);

    // crystal feeds sysclk directly or feeds the pll input, whether or not the pll is in use
    assign xtal_in_use = (status_q == ccd_pkg::SRC_XTAL)
                      || (pllsrc_q && !presel_q);
    assign force_rc = wake_from_lowpower || (crystal_failure && xtal_in_use);

    // software-owned prescaler and pll fields
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mf_q     <= 6'h00;
            usb_q    <= 3'h0;
            pllsrc_q <= 1'b0;
            presel_q <= 1'b0;
            adc_q    <= 3'h0;
            apb2_q   <= 3'h0;
            apb1_q   <= 3'h0;
            ahb_q    <= 4'h0;
        end else begin
            if (wr0) begin
                mf_q[3:0] <= wdata[ccd_pkg::MF_LSB +: 4];
                mf_q[4]   <= wdata[ccd_pkg::MF4_BIT];
                pllsrc_q  <= wdata[ccd_pkg::PLLSRC_BIT];
                adc_q[1:0] <= wdata[ccd_pkg::ADC_LSB +: 2];
                apb2_q    <= wdata[ccd_pkg::APB2_LSB +: 3];
                apb1_q    <= wdata[ccd_pkg::APB1_LSB +: 3];
                ahb_q     <= wdata[ccd_pkg::AHB_LSB +: 4];
                if (!usb_clock_enabled) begin
                    usb_q[1:0] <= wdata[ccd_pkg::USB_LSB +: 2];
                end
            end
            if (wr1) begin
                mf_q[5]  <= wdata[ccd_pkg::MF5_BIT];
                presel_q <= wdata[ccd_pkg::PRESEL_BIT];
            end
            if (wr2) begin
                adc_q[2] <= wdata[ccd_pkg::ADC2_BIT];
                if (!usb_clock_enabled) begin
                    usb_q[2] <= wdata[ccd_pkg::USB2_BIT];
                end
            end
        end
    end

    // one storage bit behind both register views
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div0_q <= 1'b0;
        end else if (wr0) begin
            div0_q <= wdata[ccd_pkg::PREDIV_BIT];
        end else if (wr1) begin
            div0_q <= wdata[ccd_pkg::DIV0_BIT];
        end
    end

    // selection: force beats a software write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= ccd_pkg::SRC_RC8;
        end else if (force_rc) begin
            sel_q <= ccd_pkg::SRC_RC8;
        end else if (wr0 && wdata[ccd_pkg::SEL_LSB +: 2] != ccd_pkg::SRC_RSVD) begin
            sel_q <= wdata[ccd_pkg::SEL_LSB +: 2];
        end
    end

    // switch sequencer; status moves once the new clock is settled, or at once to rc on a force
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_q     <= ccd_pkg::SW_IDLE;
            sw_cnt_q <= 4'h0;
            status_q <= ccd_pkg::SRC_RC8;
        end else if (force_rc) begin
            sw_q     <= ccd_pkg::SW_IDLE;
            sw_cnt_q <= 4'h0;
            status_q <= ccd_pkg::SRC_RC8;
        end else begin
            unique case (sw_q)
                ccd_pkg::SW_IDLE: begin
                    if (sel_q != status_q) begin
                        sw_q     <= ccd_pkg::SW_WAIT;
                        sw_cnt_q <= ccd_pkg::SWITCH_CYCLES;
                    end
                end
                ccd_pkg::SW_WAIT: begin
                    if (sw_cnt_q == 4'h1) begin
                        status_q <= sel_q;
                        sw_q     <= ccd_pkg::SW_IDLE;
                    end
                    sw_cnt_q <= sw_cnt_q - 4'h1;
                end
            endcase
        end
    end

    // divide ratios in source-clock events
    always_comb begin
        ahb_ratio  = ahb_q[3] ? ((ahb_q[2:0] < 3'h4) ? 10'(2 << ahb_q[1:0])
                                                    : 10'(64 << ahb_q[1:0])) : 10'h001;
        apb2_ratio = apb2_q[2] ? 10'(2 << apb2_q[1:0]) : 10'h001;
        apb1_ratio = apb1_q[2] ? 10'(2 << apb1_q[1:0]) : 10'h001;
        unique case (adc_q)
            3'h4:       adc_ratio = 10'h003;
            3'h5, 3'h6: adc_ratio = 10'h007;
            3'h7:       adc_ratio = 10'h009;
            default:    adc_ratio = 10'({adc_q[1:0], 1'b0}) + 10'h002; // widen first: code 3 gives 8
        endcase
    end

    // decoded pll and usb settings
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_multiply_q      <= 7'h02;
            usb_div_half_q      <= 3'h3;
            pll_source_sel_q    <= 1'b0;
            pll_preselect_q     <= 1'b0;
            pll_predivide_sel_q <= 1'b0;
            sysclk_in_use_q     <= ccd_pkg::SRC_RC8;
        end else begin
            if (mf_q < 6'h0f) begin
                pll_multiply_q <= 7'(mf_q) + 7'h02;
            end else begin
                pll_multiply_q <= 7'(mf_q) + 7'h01;
            end
            unique case (usb_q)
                3'h0:    usb_div_half_q <= 3'h3;
                3'h1:    usb_div_half_q <= 3'h2;
                3'h2:    usb_div_half_q <= 3'h5;
                3'h3:    usb_div_half_q <= 3'h4;
                3'h4:    usb_div_half_q <= 3'h6;
                default: usb_div_half_q <= 3'h7;
            endcase
            pll_source_sel_q    <= pllsrc_q;
            pll_preselect_q     <= presel_q;
            pll_predivide_sel_q <= div0_q;
            sysclk_in_use_q     <= status_q;
        end
    end

    // chained ticks: clk stands for the system clock
    ccd_tick #(.W(10)) u_ahb (
        .clk    (clk),
        .rst_n  (rst_n),
        .src_a  (1'b1),
        .src_b  (1'b1),
        .sel_b  (1'b0),
        .ratio  (ahb_ratio),
        .tick_q (ahb_tick_q)
    );
    ccd_tick #(.W(10)) u_apb2 (
        .clk    (clk),
        .rst_n  (rst_n),
        .src_a  (ahb_tick_q),
        .src_b  (ahb_tick_q),
        .sel_b  (1'b0),
        .ratio  (apb2_ratio),
        .tick_q (apb2_tick_q)
    );
    ccd_tick #(.W(10)) u_apb1 (
        .clk    (clk),
        .rst_n  (rst_n),
        .src_a  (ahb_tick_q),
        .src_b  (ahb_tick_q),
        .sel_b  (1'b0),
        .ratio  (apb1_ratio),
        .tick_q (apb1_tick_q)
    );
    // adc counts apb2 ticks or ahb ticks by the code's top bit
    ccd_tick #(.W(10)) u_adc (
        .clk    (clk),
        .rst_n  (rst_n),
        .src_a  (apb2_tick_q),
        .src_b  (ahb_tick_q),
        .sel_b  (adc_q[2]),
        .ratio  (adc_ratio),
        .tick_q (adc_tick_q)
    );

    // register views; unowned bits read zero
    always_comb begin
        cfg0_view = ccd_pkg::CFG_RESET;
        cfg0_view[ccd_pkg::MF4_BIT]         = mf_q[4];
        cfg0_view[ccd_pkg::USB_LSB +: 2]    = usb_q[1:0];
        cfg0_view[ccd_pkg::MF_LSB +: 4]     = mf_q[3:0];
        cfg0_view[ccd_pkg::PREDIV_BIT]      = div0_q;
        cfg0_view[ccd_pkg::PLLSRC_BIT]      = pllsrc_q;
        cfg0_view[ccd_pkg::ADC_LSB +: 2]    = adc_q[1:0];
        cfg0_view[ccd_pkg::APB2_LSB +: 3]   = apb2_q;
        cfg0_view[ccd_pkg::APB1_LSB +: 3]   = apb1_q;
        cfg0_view[ccd_pkg::AHB_LSB +: 4]    = ahb_q;
        cfg0_view[ccd_pkg::STATUS_LSB +: 2] = status_q;
        cfg0_view[ccd_pkg::SEL_LSB +: 2]    = sel_q;
        cfg1_view = ccd_pkg::CFG_RESET;
        cfg1_view[ccd_pkg::MF5_BIT]         = mf_q[5];
        cfg1_view[ccd_pkg::PRESEL_BIT]      = presel_q;
        cfg1_view[ccd_pkg::DIV0_BIT]        = div0_q;
        cfg2_view = ccd_pkg::CFG_RESET;
        cfg2_view[ccd_pkg::USB2_BIT]        = usb_q[2];
        cfg2_view[ccd_pkg::ADC2_BIT]        = adc_q[2];
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd) begin
            unique case (addr)
                ccd_pkg::CFG0_OFFSET: rdata_q <= cfg0_view;
                ccd_pkg::CFG1_OFFSET: rdata_q <= cfg1_view;
                ccd_pkg::CFG2_OFFSET: rdata_q <= cfg2_view;
                default:              rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    chk_wake_force: assert property (@(posedge clk) disable iff (!rst_n)
        wake_from_lowpower |=> (sel_q == ccd_pkg::SRC_RC8) && (status_q == ccd_pkg::SRC_RC8))
        else $error("wake did not force rc clock");
    chk_fail_force: assert property (@(posedge clk) disable iff (!rst_n)
        (crystal_failure && status_q == ccd_pkg::SRC_XTAL) |=> status_q == ccd_pkg::SRC_RC8
                                                               ##1 sysclk_in_use_q == ccd_pkg::SRC_RC8)
        else $error("crystal failure did not force rc clock");
    chk_switch_latency: assert property (@(posedge clk) disable iff (!rst_n)
        (sw_q == ccd_pkg::SW_IDLE && sel_q != status_q && !force_rc && !wr0 && !wake_from_lowpower
         && !crystal_failure) |=> (status_q != sel_q)[*3] ##1 (status_q != sel_q) ##1 (status_q == $past(sel_q, 5)))
        else $error("status not updated after switch latency");
    chk_usb_lock: assert property (@(posedge clk) disable iff (!rst_n)
        (usb_clock_enabled && (wr0 || wr2)) |=> $stable(usb_q))
        else $error("usb divider changed while usb clock on");
    chk_shared_bit: assert property (@(posedge clk) disable iff (!rst_n)
        wr1 |=> (div0_q == $past(wdata[ccd_pkg::DIV0_BIT])) ##1 (pll_predivide_sel_q == div0_q))
        else $error("shared predivide bit not written through second view");
    chk_mult_decode: assert property (@(posedge clk) disable iff (!rst_n)
        ($stable(mf_q) && mf_q == 6'h0f) |=> pll_multiply_q == 7'h10)
        else $error("multiply code 15 not times 16");
    chk_mult_top: assert property (@(posedge clk) disable iff (!rst_n)
        (wr0 && wr1 == 1'b0 && mf_q[5] && wdata[ccd_pkg::MF_LSB +: 4] == 4'hf && wdata[ccd_pkg::MF4_BIT])
        |=> ##1 pll_multiply_q == 7'h40)
        else $error("top multiply code not times 64");
    chk_usb_decode: assert property (@(posedge clk) disable iff (!rst_n)
        (usb_q == 3'h2) |=> usb_div_half_q == 3'h5)
        else $error("usb code 2 not divide by 2.5");
    chk_apb_bypass: assert property (@(posedge clk) disable iff (!rst_n)
        (!apb1_q[2] && ahb_q == 4'h0 && $past(ahb_tick_q)) |-> ##[0:20] apb1_tick_q)
        else $error("apb1 bypass produced no tick");
    chk_read_once: assert property (@(posedge clk) disable iff (!rst_n)
        (rd && addr == ccd_pkg::CFG0_OFFSET) |=> rdata_q[ccd_pkg::STATUS_LSB +: 2] == $past(status_q))
        else $error("status field read wrong");

    cov_switch_pll: cover property (@(posedge clk) disable iff (!rst_n)
        sw_q == ccd_pkg::SW_WAIT ##[1:8] status_q == ccd_pkg::SRC_PLL);
    cov_wake: cover property (@(posedge clk) disable iff (!rst_n)
        status_q == ccd_pkg::SRC_PLL ##1 wake_from_lowpower);
    cov_adc_ahb: cover property (@(posedge clk) disable iff (!rst_n) adc_q[2] && adc_tick_q);
    cov_usb_lock: cover property (@(posedge clk) disable iff (!rst_n) usb_clock_enabled && wr0);
endmodule

`default_nettype wire

// >>> logic/ccd_pkg.sv
// package of constants for the clock configuration decoder
// Notes on behaviour
// - usb divider code locked while usb clock on
// - usb codes: 1.5, 1, 2.5, 2, 3, else 3.5
// - multiply factor from three separate bit groups
// - multiply code+2, 15 gives 16, then code+1
// - predivide bit shared by two register views
// - predivide bit halves crystal or 48 MHz source
// - source bit picks rc/2 or preselected clock
// - adc code gains top bit from register two
// - adc divides apb2 by 2-8, ahb by 3/7/9
// - apb2 divider bypass or divide 2..16
// - apb1 divider bypass or divide 2..16
// - ahb divider bypass or divide 2..512
// - status field hardware-owned, reports clock in use
// - selection applied after latency, status confirms it
// - wake from low power forces rc clock
// - crystal failure in use forces rc clock
package ccd_pkg;
    // register offsets on the plain register port
    localparam logic [7:0]  CFG0_OFFSET   = 8'h04;
    localparam logic [7:0]  CFG1_OFFSET   = 8'h2c;
    localparam logic [7:0]  CFG2_OFFSET   = 8'h30;
    localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
    // clock_config_zero field positions
    localparam int MF4_BIT        = 27;
    localparam int USB_LSB        = 22;
    localparam int MF_LSB         = 18;
    localparam int PREDIV_BIT     = 17;
    localparam int PLLSRC_BIT     = 16;
    localparam int ADC_LSB        = 14;
    localparam int APB2_LSB       = 11;
    localparam int APB1_LSB       = 8;
    localparam int AHB_LSB        = 4;
    localparam int STATUS_LSB     = 2;
    localparam int SEL_LSB        = 0;
    // clock_config_one and clock_config_two field positions
    localparam int MF5_BIT        = 31;
    localparam int PRESEL_BIT     = 30;
    localparam int DIV0_BIT       = 0;
    localparam int USB2_BIT       = 30;
    localparam int ADC2_BIT       = 31;
    // system clock source codes
    localparam logic [1:0]  SRC_RC8   = 2'h0;
    localparam logic [1:0]  SRC_XTAL  = 2'h1;
    localparam logic [1:0]  SRC_PLL   = 2'h2;
    localparam logic [1:0]  SRC_RSVD  = 2'h3;
    // cycles the source switch takes before status follows
    localparam logic [3:0]  SWITCH_CYCLES = 4'h4;
    typedef enum logic {SW_IDLE, SW_WAIT} ccd_sw_state_t;
endpackage

// >>> verification/ccd_clock_model.sv
// far-side model: pll rate check and crystal and wake events
`timescale 1ns/1ns
`default_nettype none
module ccd_clock_model #(
    parameter int XTAL_KHZ  = 8000,
    parameter int LIMIT_KHZ = 108000
) (
    input  wire logic       clk,
    input  wire logic       fail_req,
    input  wire logic       wake_req,
    input  wire logic [1:0] sysclk_in_use_q,
    input  wire logic       pll_source_sel_q,
    input  wire logic       pll_preselect_q,
    input  wire logic       pll_predivide_sel_q,
    input  wire logic [6:0] pll_multiply_q,
    output logic            crystal_failure,
    output logic            wake_from_lowpower,
    output logic            over_limit_q
);
    int src_khz;
    // pll input rate: rc/2, or the preselected clock halved on request
    always_comb begin
        if (pll_source_sel_q) begin
            src_khz = (pll_preselect_q ? 48000 : XTAL_KHZ) >> pll_predivide_sel_q;
        end else begin
            src_khz = 4000;
        end
    end
    initial begin
        crystal_failure = 1'b0;
        wake_from_lowpower = 1'b0;
        over_limit_q = 1'b0;
    end
    // events leave the model one edge after they are asked for; the limit only matters once pll runs the system
    always @(posedge clk) begin
        crystal_failure <= fail_req;
        wake_from_lowpower <= wake_req;
        if (sysclk_in_use_q === ccd_pkg::SRC_PLL && src_khz * pll_multiply_q > LIMIT_KHZ) over_limit_q <= 1'b1;
    end
endmodule
`default_nettype wire

// >>> verification/clock_tree_config_decode_tb_top.sv
// self-checking bench for the clock configuration decoder
`timescale 1ns/1ns
`default_nettype none
module clock_tree_config_decode_tb_top;
    localparam logic [7:0] A0 = ccd_pkg::CFG0_OFFSET;
    localparam logic [7:0] A1 = ccd_pkg::CFG1_OFFSET;
    localparam logic [7:0] A2 = ccd_pkg::CFG2_OFFSET;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        usb_en = 1'b0;
    logic        fail_req = 1'b0;
    logic        wake_req = 1'b0;
    logic [31:0] rdata_q;
    logic        wake;
    logic        xfail;
    logic        over_limit;
    logic [1:0]  in_use;
    logic        psrc;
    logic        ppre;
    logic        pdiv;
    logic [6:0]  pmul;
    logic [2:0]  usbh;
    wire logic [3:0] tk;
    logic [31:0] c0 = 32'h0000_0000;
    logic [31:0] c1 = 32'h0000_0000;
    logic [31:0] c2 = 32'h0000_0000;
    logic [31:0] d;
    int          err_count = 0;
    int          checks = 0;

    always #20 clk = ~clk;

    ccd_top u_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
        .usb_clock_enabled(usb_en), .wake_from_lowpower(wake), .crystal_failure(xfail), .sysclk_in_use_q(in_use),
        .pll_source_sel_q(psrc), .pll_preselect_q(ppre), .pll_predivide_sel_q(pdiv), .pll_multiply_q(pmul),
        .usb_div_half_q(usbh), .ahb_tick_q(tk[0]), .apb1_tick_q(tk[1]), .apb2_tick_q(tk[2]), .adc_tick_q(tk[3]));

    ccd_clock_model u_model (.clk(clk), .fail_req(fail_req), .wake_req(wake_req), .sysclk_in_use_q(in_use),
        .pll_source_sel_q(psrc), .pll_preselect_q(ppre), .pll_predivide_sel_q(pdiv), .pll_multiply_q(pmul),
        .crystal_failure(xfail), .wake_from_lowpower(wake), .over_limit_q(over_limit));

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_per(input string what, input int exp, input int got);
        checks++;
        if (got != exp) begin
            err_count++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata_q;
    endtask
    // writes all three shadows, then lets the registered outputs settle
    task automatic put_all;
        wr_reg(A2, c2);
        wr_reg(A1, c1);
        wr_reg(A0, c0);
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic set_sel(input logic [1:0] s);
        int i;
        logic [1:0] prev;
        prev = c0[1:0];
        c0[1:0] = s;
        wr_reg(A0, c0);
        rd_reg(A0, d);
        cmp("status early", {30'h0, prev}, {30'h0, d[3:2]});
        i = 0;
        do begin
            rd_reg(A0, d);
            i++;
        end while (i < 12 && d[3:2] !== s);
        cmp("status", {30'h0, s}, {30'h0, d[3:2]});
        repeat (2) @(posedge clk);
        #1;
        cmp("in use", {30'h0, s}, {30'h0, in_use});
    endtask
    task automatic next_tk(input int w, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (tk[w] !== 1'b1 && n < 4000);
    endtask
    // old ratio may run until the divider wraps, so a few ticks pass first
    task automatic per(input string what, input int w, input int exp);
        int n;
        repeat (3) next_tk(w, n);
        next_tk(w, n);
        cmp_per(what, exp, n);
    endtask

    task automatic t_reset;
        rd_reg(A0, d);
        cmp("cfg0 reset", ccd_pkg::CFG_RESET, d);
        rd_reg(A1, d);
        cmp("cfg1 reset", ccd_pkg::CFG_RESET, d);
        rd_reg(A2, d);
        cmp("cfg2 reset", ccd_pkg::CFG_RESET, d);
        cmp("usb reset", 32'h0000_0003, {29'h0, usbh});
        cmp("mul reset", 32'h0000_0002, {25'h0, pmul});
        wr_reg(8'h08, 32'hffff_ffff);
        rd_reg(8'h08, d);
        cmp("unmapped", 32'h0000_0000, d);
        rd_reg(A0, d);
        cmp("cfg0 kept", ccd_pkg::CFG_RESET, d);
    endtask
    task automatic t_usb;
        logic [2:0] tbl [8] = '{3'h3, 3'h2, 3'h5, 3'h4, 3'h6, 3'h7, 3'h7, 3'h7};
        for (int k = 0; k < 8; k++) begin
            c2[30] = k[2];
            c0[23:22] = k[1:0];
            put_all;
            cmp("usb div", {29'h0, tbl[k]}, {29'h0, usbh});
        end
        @(posedge clk);
        usb_en <= 1'b1;
        c2[30] = 1'b0;
        c0[23:22] = 2'h0;
        put_all;
        cmp("usb locked", 32'h0000_0007, {29'h0, usbh});
        @(posedge clk);
        usb_en <= 1'b0;
        put_all;
        cmp("usb 1.5", 32'h0000_0003, {29'h0, usbh});
    endtask
    task automatic t_mult;
        logic [5:0] m;
        for (int k = 0; k < 64; k++) begin
            m = k[5:0];
            c1[31] = m[5];
            c0[27] = m[4];
            c0[21:18] = m[3:0];
            put_all;
            cmp("multiply", (k < 15) ? k + 2 : (k == 15) ? 16 : k + 1, {25'h0, pmul});
        end
        c1[31] = 1'b0;
        c0[27] = 1'b0;
        c0[21:18] = 4'h0;
        put_all;
    endtask
    task automatic t_pll;
        c0[17] = 1'b1;
        c1[0] = 1'b1;
        wr_reg(A0, c0);
        rd_reg(A1, d);
        cmp("cfg1 div bit", 32'h0000_0001, {31'h0, d[0]});
        cmp("predivide", 32'h0000_0001, {31'h0, pdiv});
        c0[17] = 1'b0;
        c1[0] = 1'b0;
        wr_reg(A1, c1);
        rd_reg(A0, d);
        cmp("cfg0 div bit", 32'h0000_0000, {31'h0, d[17]});
        c0[16] = 1'b1;
        c1[30] = 1'b1;
        put_all;
        cmp("src presel", 32'h0000_0003, {30'h0, psrc, ppre});
        c0[16] = 1'b0;
        c1[30] = 1'b0;
        put_all;
    endtask
    task automatic t_ticks;
        int ahb [16] = '{1, 1, 1, 1, 1, 1, 1, 1, 2, 4, 8, 16, 64, 128, 256, 512};
        int apb [8] = '{1, 1, 1, 1, 2, 4, 8, 16};
        int hi [4] = '{3, 7, 7, 9};
        for (int k = 0; k < 16; k++) begin
            c0[7:4] = k[3:0];
            put_all;
            per("ahb period", 0, ahb[k]);
        end
        // ahb at half rate: the apb and adc periods below count in pairs of cycles
        c0[7:4] = 4'h8;
        for (int k = 0; k < 8; k++) begin
            c0[13:11] = k[2:0];
            c0[10:8] = 3'h7 - k[2:0];
            put_all;
            per("apb2 period", 2, 2 * apb[k]);
            per("apb1 period", 1, 2 * apb[7 - k]);
        end
        c0[13:11] = 3'h4;
        for (int k = 0; k < 8; k++) begin
            c2[31] = k[2];
            c0[15:14] = k[1:0];
            put_all;
            per("adc period", 3, (k < 4) ? 8 * (k + 1) : 2 * hi[k - 4]);
        end
        c0[15:4] = 12'h000;
        c2[31] = 1'b0;
        put_all;
    endtask
    task automatic t_switch;
        set_sel(ccd_pkg::SRC_XTAL);
        set_sel(ccd_pkg::SRC_PLL);
        set_sel(ccd_pkg::SRC_RC8);
        wr_reg(A0, c0 | 32'h0000_000f);
        rd_reg(A0, d);
        cmp("reserved sel", 32'h0000_0000, {28'h0, d[3:0]});
    endtask
    task automatic t_force;
        logic fsrc [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        logic fpre [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
        logic fgo [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        logic [1:0] fsel [4] = '{2'h1, 2'h2, 2'h2, 2'h2};
        set_sel(ccd_pkg::SRC_XTAL);
        @(posedge clk);
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        cmp("wake in use", 32'h0000_0000, {30'h0, in_use});
        rd_reg(A0, d);
        cmp("wake fields", 32'h0000_0000, {28'h0, d[3:0]});
        c0[1:0] = 2'h0;
        for (int k = 0; k < 4; k++) begin
            c0[16] = fsrc[k];
            c1[30] = fpre[k];
            put_all;
            set_sel(fsel[k]);
            @(posedge clk);
            fail_req <= 1'b1;
            repeat (4) @(posedge clk);
            #1;
            cmp("fail in use", fgo[k] ? 32'h0000_0000 : {30'h0, fsel[k]}, {30'h0, in_use});
            @(posedge clk);
            fail_req <= 1'b0;
            if (fgo[k]) c0[1:0] = 2'h0;
            set_sel(ccd_pkg::SRC_RC8);
        end
        c0[16] = 1'b0;
        c1[30] = 1'b0;
        put_all;
        cmp("pll limit", 32'h0000_0000, {31'h0, over_limit});
    endtask

    task automatic wrap_up;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // roughly 6k cycles of tests; the watchdog allows more than five times that
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        $display("Error watchdog expected done seen timeout");
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_usb;
        t_mult;
        t_pll;
        t_switch;
        t_force;
        t_ticks;
        wrap_up;
    end
endmodule
`default_nettype wire
